// >>> rtl/lta_params.svh
`ifndef LTA_PARAMS_SVH
`define LTA_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LTA_OFF_INDEX0 12'h410
`define LTA_OFF_INDEX1 12'h414
`define LTA_OFF_ACC_CTRL 12'h418
`define LTA_OFF_FIX_CTRL 12'h41c
`define LTA_OFF_ENTRY1 12'h420
`define LTA_OFF_ENTRY2 12'h424
`define LTA_OFF_ENTRY3 12'h428
`define LTA_OFF_ENTRY4 12'h42c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LTA_BIT_GO 7
`define LTA_BIT_READY 6
`define LTA_BIT_READY_OR_END 5
`define LTA_BIT_DIRECT 2
`define LTA_BIT_TABLE_SEL 1
`define LTA_BIT_FIX_READ 0
`define LTA_CNT_LSB 16
`define LTA_CNT_MSB 29
`define LTA_SLOT_LSB 16
`define LTA_SLOT_MSB 21

// ----------------------------------------
// Table sizes and reset values
// ----------------------------------------
`define LTA_LUT_DEPTH 4096
`define LTA_FIX_DEPTH 16
`define LTA_MC_DEPTH 64
`define LTA_ZERO32 32'h0000_0000

`endif

// >>> rtl/lta_pkg.sv
package lta_pkg;

  // Lookup table operation codes
  typedef enum logic [1:0] {
    LTA_OP_NOP = 2'h0,
    LTA_OP_WRITE = 2'h1,
    LTA_OP_READ = 2'h2,
    LTA_OP_SEARCH = 2'h3
  } lta_op_type;

  // Register access from the management port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } lta_req_type;

  // Four entry-value words of a lookup or static entry
  typedef struct packed {
    logic [31:0] w4;
    logic [31:0] w3;
    logic [31:0] w2;
    logic [31:0] w1;
  } lta_entry_type;

endpackage

// >>> rtl/lta_hash.sv
`timescale 1ns/1ns
`include "lta_params.svh"

// ----------------------------------------
// Lookup table index: hash or direct
// ----------------------------------------
module lta_hash (
  input wire logic direct_i,
  input wire logic [6:0] fid_i,
  input wire logic [47:0] mac_i,
  output logic [11:0] index_o
);
  import lta_pkg::*;

  logic [11:0] folded;

  // Fold filter id and address into twelve bits
  always_comb begin
    folded = mac_i[11:0] ^ mac_i[23:12] ^ mac_i[35:24] ^ mac_i[47:36] ^ {5'h00, fid_i};
    index_o = direct_i ? mac_i[11:0] : folded;
  end

endmodule

// >>> rtl/lta_ctrl.sv
`timescale 1ns/1ns
`include "lta_params.svh"

// How it works
// - Writing go bit starts a lookup table operation; hardware clears it when done.
// - Operation code: 00 none, 01 write, 10 read, 11 search for valid entries.
// - Search end reports valid entry count in read-only bits 29:16.
// - Ready flag bit 6 sets per found entry, clears on reading entry word four.
// - Bit 5 reads one when ready flag set or search has ended.
// - Bit 2 chooses direct indexing when one, hashed indexing when zero.
// - Four entry words serve lookup and static tables; multicast uses word two.
// - Bit 7 of fixed table control starts access; it is never stored and always reads zero.
// - Table choice bit 1: one multicast table, zero static table.
// - Bit 0 of fixed table control: one read, zero write.
// - Slot index bits 21:16 for multicast table, bits 19:16 for static table.
// - Direct indexing uses low twelve bits of lower index register.
// - Hashed indexing combines seven-bit filter id and 48-bit address.
module lta_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lta_pkg::lta_req_type req_i,
  output logic [31:0] rdata_o
);
  import lta_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  lta_entry_type lut_mem [`LTA_LUT_DEPTH];
  logic [`LTA_LUT_DEPTH-1:0] lut_valid;
  lta_entry_type fix_mem [`LTA_FIX_DEPTH];
  logic [31:0] mc_mem [`LTA_MC_DEPTH];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] index0;
  logic [31:0] index1;
  lta_entry_type entry;
  logic lut_go;
  logic lut_ready;
  logic search_end;
  logic lut_direct;
  logic [1:0] lut_rsvd;
  lta_op_type lut_op;
  logic [13:0] valid_count;
  logic fix_go;
  logic [4:0] fix_rsvd;
  logic fix_sel_mc;
  logic fix_read;
  logic [5:0] fix_slot;

  // Search walker
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_HOLD = 3'b100
  } lta_state_type;
  lta_state_type state;
  lta_state_type next_state;
  logic [12:0] scan_pos;
  logic [11:0] lut_index;

  logic wr_acc;
  logic wr_fix;
  logic rd_word4;
  logic lut_start;
  logic scan_hit;
  logic scan_last;

  assign wr_acc = req_i.wr && req_i.addr == `LTA_OFF_ACC_CTRL;
  assign wr_fix = req_i.wr && req_i.addr == `LTA_OFF_FIX_CTRL;
  assign rd_word4 = req_i.rd && req_i.addr == `LTA_OFF_ENTRY4;
  assign lut_start = wr_acc && req_i.wdata[`LTA_BIT_GO] && !lut_go;
  assign scan_hit = lut_valid[scan_pos[11:0]];
  assign scan_last = scan_pos[11:0] == 12'hfff;

  // Indexing follows the direct bit of the start word itself
  lta_hash u_hash (
    .direct_i(req_i.wdata[`LTA_BIT_DIRECT]),
    .fid_i(index0[22:16]),
    .mac_i({index0[15:0], index1}),
    .index_o(lut_index)
  );

  // ----------------------------------------
  // Index and control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index0 <= `LTA_ZERO32;
      index1 <= `LTA_ZERO32;
    end else begin
      if (req_i.wr && req_i.addr == `LTA_OFF_INDEX0) begin
        index0 <= {req_i.wdata[31], 8'h00, req_i.wdata[22:0]};
      end
      if (req_i.wr && req_i.addr == `LTA_OFF_INDEX1) begin
        index1 <= req_i.wdata;
      end
    end
  end

  // Lookup control fields, writable only while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_direct <= 1'b0;
      lut_rsvd <= 2'h0;
      lut_op <= LTA_OP_NOP;
    end else if (wr_acc && !lut_go) begin
      lut_direct <= req_i.wdata[`LTA_BIT_DIRECT];
      lut_rsvd <= req_i.wdata[4:3];
      lut_op <= lta_op_type'(req_i.wdata[1:0]);
    end
  end

  // Fixed table control fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fix_rsvd <= 5'h00;
      fix_sel_mc <= 1'b0;
      fix_read <= 1'b0;
      fix_slot <= 6'h00;
    end else if (wr_fix && !fix_go) begin
      fix_rsvd <= req_i.wdata[6:2];
      fix_sel_mc <= req_i.wdata[`LTA_BIT_TABLE_SEL];
      fix_read <= req_i.wdata[`LTA_BIT_FIX_READ];
      fix_slot <= req_i.wdata[`LTA_SLOT_MSB:`LTA_SLOT_LSB];
    end
  end

  // ----------------------------------------
  // Lookup table sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (lut_start && req_i.wdata[1:0] == LTA_OP_SEARCH) begin
          next_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (scan_hit) begin
          next_state = ST_HOLD;
        end else if (scan_last) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (rd_word4) begin
          next_state = scan_last ? ST_IDLE : ST_SCAN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Scan position advances past each examined slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_pos <= 13'h0000;
    end else if (state == ST_IDLE) begin
      scan_pos <= 13'h0000;
    end else if ((state == ST_SCAN && !scan_hit) || (state == ST_HOLD && rd_word4)) begin
      scan_pos <= scan_pos + 13'h0001;
    end
  end

  // Go bit and search-ended flag; the flag drops on the next start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_go <= 1'b0;
      search_end <= 1'b0;
    end else if (lut_start) begin
      lut_go <= req_i.wdata[1:0] == LTA_OP_SEARCH;
      search_end <= 1'b0;
    end else if (state != ST_IDLE && next_state == ST_IDLE) begin
      lut_go <= 1'b0;
      search_end <= 1'b1;
    end
  end

  // Ready flag for each entry found during search
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_ready <= 1'b0;
    end else if (state == ST_SCAN && scan_hit) begin
      lut_ready <= 1'b1;
    end else if (rd_word4) begin
      lut_ready <= 1'b0;
    end
  end

  // Valid entry count, published when a search ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_count <= 14'h0000;
    end else if (state != ST_IDLE && next_state == ST_IDLE) begin
      valid_count <= 14'($countones(lut_valid));
    end
  end

  // ----------------------------------------
  // Entry words and table accesses
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry <= '0;
    end else if (state == ST_SCAN && scan_hit) begin
      entry <= lut_mem[scan_pos[11:0]];
    end else if (lut_start && req_i.wdata[1:0] == LTA_OP_READ) begin
      entry <= lut_mem[lut_index];
    end else if (wr_fix && !fix_go && req_i.wdata[`LTA_BIT_GO]
                 && req_i.wdata[`LTA_BIT_FIX_READ]) begin
      if (req_i.wdata[`LTA_BIT_TABLE_SEL]) begin
        entry.w2 <= mc_mem[req_i.wdata[21:16]];
      end else begin
        entry <= fix_mem[req_i.wdata[19:16]];
      end
    end else if (req_i.wr && !lut_go) begin
      case (req_i.addr)
        `LTA_OFF_ENTRY1: entry.w1 <= req_i.wdata;
        `LTA_OFF_ENTRY2: entry.w2 <= req_i.wdata;
        `LTA_OFF_ENTRY3: entry.w3 <= req_i.wdata;
        `LTA_OFF_ENTRY4: entry.w4 <= req_i.wdata;
        default: entry <= entry;
      endcase
    end
  end

  // Lookup table writes; an entry is valid once written nonzero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_valid <= '0;
    end else if (lut_start && req_i.wdata[1:0] == LTA_OP_WRITE) begin
      lut_mem[lut_index] <= entry;
      lut_valid[lut_index] <= |entry;
    end
  end

  // Static and multicast writes finish in one cycle
  always_ff @(posedge clk_i) begin
    if (wr_fix && !fix_go && req_i.wdata[`LTA_BIT_GO] && !req_i.wdata[`LTA_BIT_FIX_READ]) begin
      if (req_i.wdata[`LTA_BIT_TABLE_SEL]) begin
        mc_mem[req_i.wdata[21:16]] <= entry.w2;
      end else begin
        fix_mem[req_i.wdata[19:16]] <= entry;
      end
    end
  end

  // Fixed table go bit is never set; it always reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fix_go <= 1'b0;
    end else begin
      fix_go <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= `LTA_ZERO32;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `LTA_OFF_INDEX0: rdata_o <= index0;
        `LTA_OFF_INDEX1: rdata_o <= index1;
        `LTA_OFF_ACC_CTRL: rdata_o <= {2'h0, valid_count, 8'h00, lut_go, lut_ready,
                                       lut_ready | search_end, lut_rsvd, lut_direct,
                                       lut_op};
        `LTA_OFF_FIX_CTRL: rdata_o <= {10'h000, fix_slot, 8'h00, fix_go, fix_rsvd,
                                       fix_sel_mc, fix_read};
        `LTA_OFF_ENTRY1: rdata_o <= entry.w1;
        `LTA_OFF_ENTRY2: rdata_o <= entry.w2;
        `LTA_OFF_ENTRY3: rdata_o <= entry.w3;
        `LTA_OFF_ENTRY4: rdata_o <= entry.w4;
        default: rdata_o <= `LTA_ZERO32;
      endcase
    end
  end

endmodule

// >>> test/lta_ctrl_props.sv
`timescale 1ns/1ns
module lta_ctrl_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lta_pkg::lta_req_type req_i,
  input wire logic [31:0] rdata_o
);
  import lta_pkg::*;
  // ----------------------------------------
  // Decoded reads and writes
  // ----------------------------------------
  logic rd_ctl;
  logic rd_fix;
  logic rd_x;
  logic wr_i1;
  logic rd_i1;
  assign rd_ctl = req_i.rd && req_i.addr == 12'h418;
  assign rd_fix = req_i.rd && req_i.addr == 12'h41c;
  assign rd_x = req_i.rd && (req_i.addr < 12'h410 || req_i.addr > 12'h42f);
  assign wr_i1 = req_i.wr && req_i.addr == 12'h414;
  assign rd_i1 = req_i.rd && req_i.addr == 12'h414;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst;
    disable iff (1'b0) rst_i |=> rdata_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("read data not cleared by reset");
  property p_hold;
    !req_i.rd |=> $stable(rdata_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  property p_mix;
    rd_ctl |=> (rdata_o[5] || !rdata_o[6]) && !(rdata_o[5] && rdata_o[7] && !rdata_o[6]);
  endproperty
  a_mix: assert property (p_mix)
    else $error("combined flag wrong");
  property p_ctl_rsv;
    rd_ctl |=> rdata_o[31:30] == 2'h0 && rdata_o[15:8] == 8'h0;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv)
    else $error("control reserved bits set");
  property p_fix;
    rd_fix |=> !rdata_o[7] && rdata_o[31:22] == 10'h0 && rdata_o[15:8] == 8'h0;
  endproperty
  a_fix: assert property (p_fix)
    else $error("fixed control read wrong");
  property p_unmap;
    rd_x |=> rdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_idx1;
    wr_i1 ##2 rd_i1 |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_idx1: assert property (p_idx1)
    else $error("index word one lost");
  property p_idx0;
    req_i.rd && req_i.addr == 12'h410 |=> rdata_o[30:23] == 8'h0;
  endproperty
  a_idx0: assert property (p_idx0)
    else $error("index word zero reserved set");
  c_ready: cover property (rd_ctl ##1 rdata_o[6]);
  c_count: cover property (rd_ctl ##1 rdata_o[29:16] != 14'h0);
  c_fix: cover property (rd_fix);
endmodule

bind lta_ctrl lta_ctrl_props chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
  .rdata_o(rdata_o));

// >>> test/lta_host.sv
`timescale 1ns/1ns
module lta_host (
  input wire logic clk_i,
  output lta_pkg::lta_req_type req_o,
  input wire logic [31:0] rdata_i
);
  import lta_pkg::*;
  initial req_o = '0;
  // One access, idle cycle before it, data taken at its edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    q = rdata_i;
    req_o = '0;
  endtask
endmodule

// >>> test/tb_lta_ctrl.sv
`timescale 1ns/1ns
module tb_lta_ctrl;
  import lta_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  lta_req_type req;
  logic [31:0] rdata;
  logic [31:0] q;
  int error_cnt = 0;
  int checked = 0;
  lta_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata));
  lta_host h (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
  initial forever #2 clk_i = ~clk_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    h.acc(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    h.acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic went(input logic [31:0] b);
    for (int i = 0; i < 4; i++) begin
      wr(12'h420 + 12'(4 * i), b + i);
    end
  endtask
  task automatic rent(input logic [31:0] b);
    for (int i = 0; i < 4; i++) begin
      rc(12'h420 + 12'(4 * i), b + i);
    end
  endtask
  // Poll the lookup control word until bit b equals v
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 3000; n++) begin
      h.acc(1'b0, 12'h418, 32'h0, q);
      if (q[b] === v) break;
    end
    chk({31'h0, q[b]}, {31'h0, v});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 'h410; a <= 'h42c; a += 4) begin
      rc(12'(a), 32'h0);
    end
    rc(12'h400, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_search;
    wr(12'h414, 32'h5);
    went(32'h100);
    wr(12'h418, 32'h85);
    rc(12'h418, 32'h05);
    wr(12'h414, 32'hfff);
    went(32'h200);
    wr(12'h418, 32'h85);
    wr(12'h414, 32'h5);
    went(32'h0);
    wr(12'h418, 32'h86);
    rent(32'h100);
    wr(12'h418, 32'h83);
    poll(6, 1'b1);
    rent(32'h100);
    rc(12'h418, 32'h83);
    poll(6, 1'b1);
    rent(32'h200);
    poll(7, 1'b0);
    rc(12'h418, 32'h0002_0023);
    $display("test search done");
  endtask
  task automatic t_hash;
    wr(12'h414, 32'h1234_5678);
    rc(12'h414, 32'h1234_5678);
    wr(12'h410, 32'hff92_abcd);
    rc(12'h410, 32'h8012_abcd);
    went(32'h500);
    wr(12'h418, 32'h85);
    went(32'h300);
    wr(12'h418, 32'h81);
    went(32'h0);
    wr(12'h418, 32'h82);
    rent(32'h300);
    went(32'h0);
    wr(12'h418, 32'h86);
    rent(32'h500);
    went(32'h7);
    wr(12'h418, 32'h80);
    rc(12'h420, 32'h7);
    $display("test hash done");
  endtask
  task automatic t_fixed;
    went(32'h400);
    wr(12'h41c, 32'h0003_0080);
    wr(12'h424, 32'h5a5a_0001);
    wr(12'h41c, 32'h0025_0082);
    went(32'h0);
    wr(12'h41c, 32'h0013_0081);
    rent(32'h400);
    rc(12'h41c, 32'h0013_0001);
    went(32'h0);
    wr(12'h41c, 32'h0025_0083);
    rc(12'h424, 32'h5a5a_0001);
    rc(12'h420, 32'h0);
    $display("test fixed done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_search();
    t_hash();
    t_fixed();
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
